/* File: design/bbh_pkg.sv */
package bbh_pkg;
  localparam logic [7:0] BBH_ID_CONFIG    = 8'hff;
  localparam logic [7:0] BBH_ID_CMD_BASE  = 8'h50;
  localparam logic [7:0] BBH_ID_FIRST     = 8'h00;
  localparam logic [7:0] BBH_ERR_NO_CTS   = 8'hff;
  localparam logic [7:0] BBH_ERR_CFG      = 8'h01;
  localparam logic [7:0] BBH_ERR_NONE     = 8'h00;
  localparam logic [7:0] BBH_MAX_CMD_BLKS = 8'h14;
  localparam logic [3:0] BBH_MAX_BAUD     = 4'h7;
  localparam logic [7:0] BBH_RST_CMD_BLKS = 8'h00;
  localparam logic [7:0] BBH_RST_DATA_BLKS = 8'h01;
  localparam int         BBH_FIFO_DEPTH   = 8;
endpackage

/* File: design/bbh_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// backplane transfer link between host and device
interface bbh_link_if;
  logic [7:0]  req_id;    // block id requested by device
  logic        req_valid; // device asks for a write block
  logic        wr_valid;  // host delivers block_transfer_write
  logic [7:0]  wr_id;     // block id carried by the write
  logic [15:0] wr_data;   // one word of the block
  logic        wr_ready;  // device can take the word
  modport dev  (output req_id, req_valid, wr_ready, input wr_valid, wr_id, wr_data);
  modport host (input req_id, req_valid, wr_ready, output wr_valid, wr_id, wr_data);
endinterface
`default_nettype wire

/* File: design/bbh_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bbh_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         ref_clk,  // clock
  input  wire logic         rst_n,    // async reset
  input  wire logic         in_valid, // write side valid
  output logic              in_ready, // write side ready
  input  wire logic [W-1:0] in_data,  // write data
  output logic              out_valid,// read side valid
  input  wire logic         out_ready,// read side ready
  output logic [W-1:0]      out_data  // read data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  // pointers and count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
  // storage
  always_ff @(posedge ref_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule
`default_nettype wire

/* File: design/bbh_device.sv */
`timescale 1ns/1ps
`default_nettype none
module bbh_device import bbh_pkg::*; #(
  parameter int NPORT = 2
) (
  input  wire logic             ref_clk,     // clock
  input  wire logic             rst_n,       // async reset
  bbh_link_if.dev               link,        // backplane link
  input  wire logic [NPORT-1:0] cts,         // clear-to-send per port
  input  wire logic [NPORT-1:0] rx_line,     // receive line level
  input  wire logic [NPORT-1:0] tx_want,     // engine has a byte to send
  input  wire logic [NPORT-1:0] tx_line_in,  // engine transmit level
  output logic [NPORT-1:0]      tx_line,     // gated transmit line
  output logic [NPORT-1:0]      tx_go,       // transmit allowed
  output logic [NPORT-1:0]      port_receive_indicator, // rx activity
  output logic [NPORT-1:0]      tx_indicator,// tx activity
  output logic [NPORT*8-1:0]    port_status, // error code per port
  output logic                  cfg_indicator,// configuration light
  output logic [7:0]            cmd_blocks,  // adopted command block count
  output logic [7:0]            data_blocks, // adopted data block count
  output logic                  data_valid,  // stored word available
  input  wire logic             data_ready,  // consumer takes word
  output logic [15:0]           data_word,   // stored word
  output logic [7:0]            data_id      // id of current block
);
  typedef enum logic {S_DATA, S_CMD} bbh_seq_type;
  bbh_seq_type seq_q;
  logic [7:0] req_id_q, cur_id_q, cmd_q, dat_q;
  logic       cfg_err_q, cfg_led_q, cfg_seen_q;
  logic [NPORT-1:0] txl_q, go_q, rxi_q, txi_q;
  logic [NPORT*8-1:0] st_q;
  logic [15:0] fdat;
  logic        fvalid;
  // word decode of the write block
  wire take     = link.wr_valid && link.wr_ready;
  wire is_cfg   = take && (link.wr_id == BBH_ID_CONFIG);
  wire [7:0] new_cmd  = link.wr_data[7:0];
  wire [7:0] new_dat  = link.wr_data[15:8];
  wire cfg_bad  = (new_cmd > BBH_MAX_CMD_BLKS) || (new_dat == 8'h00);
  wire is_data  = take && !is_cfg;
  wire last_cmd = (req_id_q == BBH_ID_CMD_BASE + cmd_q - 8'h01);
  wire last_dat = (req_id_q == dat_q - 8'h01);
  assign link.req_id    = req_id_q;
  assign link.req_valid = 1'b1;
  // data words go through the fifo, stalling the link when full
  bbh_fifo #(.W(16), .D(BBH_FIFO_DEPTH)) i_bbh_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .in_valid (is_data),
    .in_ready (link.wr_ready),
    .in_data  (link.wr_data),
    .out_valid(fvalid),
    .out_ready(data_ready),
    .out_data (fdat)
  );
  assign data_valid = fvalid;
  assign data_word  = fdat;
  // configuration adoption and indicator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q      <= BBH_RST_CMD_BLKS;
      dat_q      <= BBH_RST_DATA_BLKS;
      cfg_err_q  <= 1'b0;
      cfg_seen_q <= 1'b0;
      cfg_led_q  <= 1'b1;
    end else if (is_cfg) begin
      cfg_seen_q <= 1'b1;
      cfg_err_q  <= cfg_bad;
      cfg_led_q  <= cfg_bad;
      if (!cfg_bad) begin
        cmd_q <= new_cmd;
        dat_q <= new_dat;
      end
    end else begin
      cfg_led_q <= cfg_err_q || !cfg_seen_q;
    end
  end
  // requested id sequence: data ids from 0, then command ids from 80
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q    <= S_DATA;
      req_id_q <= BBH_ID_FIRST;
      cur_id_q <= BBH_ID_FIRST;
    end else if (is_cfg) begin
      seq_q    <= S_DATA;
      req_id_q <= BBH_ID_FIRST;
    end else if (is_data) begin
      cur_id_q <= link.wr_id;
      unique case (seq_q)
        S_DATA: begin
          if (!last_dat) begin
            req_id_q <= req_id_q + 8'h01;
          end else if (cmd_q != 8'h00) begin
            seq_q    <= S_CMD;
            req_id_q <= BBH_ID_CMD_BASE;
          end else begin
            req_id_q <= BBH_ID_FIRST;
          end
        end
        S_CMD: begin
          if (!last_cmd) begin
            req_id_q <= req_id_q + 8'h01;
          end else begin
            seq_q    <= S_DATA;
            req_id_q <= BBH_ID_FIRST;
          end
        end
      endcase
    end
  end
  // per port status, gating and line-following indicators
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= '0;
      txl_q <= '1;
      go_q  <= '0;
      rxi_q <= '0;
      txi_q <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        go_q[i]  <= tx_want[i] && cts[i];
        txl_q[i] <= cts[i] ? tx_line_in[i] : 1'b1;
        rxi_q[i] <= !rx_line[i];
        txi_q[i] <= cts[i] && !tx_line_in[i];
        st_q[i*8 +: 8] <= !cts[i] ? BBH_ERR_NO_CTS :
                          cfg_err_q ? BBH_ERR_CFG : BBH_ERR_NONE;
      end
    end
  end
  assign tx_line                = txl_q;
  assign tx_go                  = go_q;
  assign port_receive_indicator = rxi_q;
  assign tx_indicator           = txi_q;
  assign port_status            = st_q;
  assign cfg_indicator          = cfg_led_q;
  assign cmd_blocks             = cmd_q;
  assign data_blocks            = dat_q;
  assign data_id                = cur_id_q;
endmodule
`default_nettype wire

/* File: design/bbh_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bbh_host import bbh_pkg::*; (
  input  wire logic        ref_clk,    // clock
  input  wire logic        rst_n,      // async reset
  bbh_link_if.host         link,       // backplane link
  input  wire logic        user_cfg,   // pulse: send configuration
  input  wire logic [15:0] cfg_word,   // config word: data blks hi, cmd blks lo
  input  wire logic [15:0] user_data,  // word for requested block
  input  wire logic [7:0]  host_paths, // write paths provided
  output logic             busy        // write pending
);
  logic        pend_q, cfgp_q, busy_q;
  logic [7:0]  id_q;
  logic [15:0] d_q;
  // a path exists only for data ids or command ids inside host_paths
  wire in_cmd   = (link.req_id >= BBH_ID_CMD_BASE);
  wire has_path = !in_cmd || (link.req_id < BBH_ID_CMD_BASE + host_paths);
  // one write at a time; a config pulse during a pending write is held in cfgp_q
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      cfgp_q <= 1'b0;
      id_q   <= BBH_ID_FIRST;
      d_q    <= '0;
    end else if (pend_q) begin
      if (link.wr_ready) pend_q <= 1'b0;
      cfgp_q <= cfgp_q || user_cfg;
    end else if (user_cfg || cfgp_q) begin
      pend_q <= 1'b1;
      cfgp_q <= 1'b0;
      id_q   <= BBH_ID_CONFIG;
      d_q    <= cfg_word;
    end else if (link.req_valid && has_path) begin
      pend_q <= 1'b1;
      id_q   <= link.req_id;
      d_q    <= user_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_q <= 1'b0;
    else        busy_q <= pend_q;
  end
  assign link.wr_valid = pend_q;
  assign link.wr_id    = id_q;
  assign link.wr_data  = d_q;
  assign busy          = busy_q;
endmodule
`default_nettype wire

/* File: dv/bbh_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module bbh_link_chk (
  input wire logic        ref_clk,                // clock
  input wire logic        rst_n,                  // async reset
  input wire logic [7:0]  req_id,                 // requested id
  input wire logic        req_valid,              // request on
  input wire logic        wr_valid,               // write valid
  input wire logic [7:0]  wr_id,                  // write id
  input wire logic [15:0] wr_data,                // write word
  input wire logic        wr_ready,               // write ready
  input wire logic [1:0]  cts,                    // clear-to-send
  input wire logic [1:0]  rx_line,                // receive lines
  input wire logic [1:0]  tx_go,                  // transmit allowed
  input wire logic [1:0]  tx_line,                // gated transmit
  input wire logic [1:0]  port_receive_indicator, // rx lights
  input wire logic [15:0] port_status,            // status codes
  input wire logic        cfg_indicator,          // config light
  input wire logic [7:0]  cmd_blocks,             // command count
  input wire logic [7:0]  data_blocks             // data count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // taken words and configuration decode
  wire take = wr_valid && wr_ready;
  wire cfg_in = take && wr_id == 8'hff;
  wire cfg_ok = cfg_in && wr_data[7:0] <= 8'h14 && wr_data[15:8] != 8'h00;
  wire hit = take && wr_id == req_id;
  sequence s_data_end;
    hit && wr_id == data_blocks - 8'h01;
  endsequence
  sequence s_cmd_end;
    hit && cmd_blocks != 8'h00 && wr_id == 8'h4f + cmd_blocks;
  endsequence
  // adoption, indicator and sequencing
  adopt_only_a: assert property ($changed(cmd_blocks) |-> $past(cfg_ok))
    else $error("count moved");
  cfg_clear_a: assert property (cfg_ok |=> !cfg_indicator && req_id == 8'h00)
    else $error("cfg");
  cfg_err_a: assert property (cfg_in && !cfg_ok |=> cfg_indicator)
    else $error("cfg err light");
  req_on_a: assert property (req_valid) else $error("request dropped");
  req_hold_a: assert property (!take |=> $stable(req_id)) else $error("req id moved");
  data_step_a: assert property (hit && wr_id < 8'h50 && wr_id + 8'h01 < data_blocks
    |=> req_id == $past(req_id) + 8'h01) else $error("data step");
  cmd_start_a: assert property (s_data_end ##0 cmd_blocks != 8'h00 |=> req_id == 8'h50)
    else $error("cmd start");
  wrap_zero_a: assert property (s_cmd_end |=> req_id == 8'h00) else $error("wrap");
  // port side
  cts_code_a: assert property (1 |=> (port_status[7:0] == 8'hff) == !$past(cts[0]))
    else $error("cts code");
  tx_block_a: assert property (!cts[1] |=> !tx_go[1] && tx_line[1]) else $error("tx");
  rx_light_a: assert property (1 |=> port_receive_indicator[0] == !$past(rx_line[0]))
    else $error("rx light");
endmodule
`default_nettype wire

/* File: dv/backplane_block_id_handler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module backplane_block_id_handler_tb;
  import bbh_pkg::*;
  logic ref_clk, rst_n, user_cfg, data_ready, cfg_indicator, data_valid, busy;
  logic [1:0] cts, rx_line, tx_want, tx_line_in, tx_line, tx_go, rxi, txi;
  logic [15:0] cfg_word, user_data, port_status, data_word;
  logic [7:0] host_paths, cmd_blocks, data_blocks, data_id, p;
  int err_count, n_tests, cyc;
  bbh_link_if link();
  bbh_device i_bbh_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cts(cts),
    .rx_line(rx_line), .tx_want(tx_want), .tx_line_in(tx_line_in), .tx_line(tx_line),
    .tx_go(tx_go), .port_receive_indicator(rxi), .tx_indicator(txi),
    .port_status(port_status), .cfg_indicator(cfg_indicator), .cmd_blocks(cmd_blocks),
    .data_blocks(data_blocks), .data_valid(data_valid), .data_ready(data_ready),
    .data_word(data_word), .data_id(data_id));
  bbh_host i_bbh_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .user_cfg(user_cfg),
    .cfg_word(cfg_word), .user_data(user_data), .host_paths(host_paths), .busy(busy));
  bbh_link_chk i_bbh_link_chk (.ref_clk(ref_clk), .rst_n(rst_n), .req_id(link.req_id),
    .req_valid(link.req_valid), .wr_valid(link.wr_valid), .wr_id(link.wr_id),
    .wr_data(link.wr_data), .wr_ready(link.wr_ready), .cts(cts), .rx_line(rx_line),
    .tx_go(tx_go), .tx_line(tx_line), .port_receive_indicator(rxi),
    .port_status(port_status), .cfg_indicator(cfg_indicator), .cmd_blocks(cmd_blocks),
    .data_blocks(data_blocks));
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // send one configuration block and judge adoption
  task automatic t_cfg(input logic [15:0] w, input logic ok, input logic [15:0] exp);
    @(negedge ref_clk) {user_cfg, cfg_word} = {1'b1, w};
    @(negedge ref_clk) user_cfg = 1'b0;
    // look between edges for the config word that the next rising edge takes
    repeat (20) begin
      if (link.wr_valid && link.wr_ready && link.wr_id == 8'hff) break;
      @(negedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    chk({data_blocks, cmd_blocks} === exp, "adopted counts");
    chk(cfg_indicator === !ok, "config light");
    chk(port_status === (ok ? 16'h0000 : 16'h0101), "config error code");
  endtask
  // ids 0,1 then 80,81 then back to 0
  task automatic t_seq();
    p = 8'hfe;
    repeat (300) @(negedge ref_clk)
      if (link.wr_valid && link.wr_ready && link.wr_id != 8'hff) begin
        if (p != 8'hfe) chk(link.wr_id === ((p == 8'h01) ? 8'h50 : (p == 8'h51) ? 8'h00
          : p + 8'h01) && data_id === p, "id order");
        p = link.wr_id;
      end
    chk(p !== 8'hfe, "writes seen");
  endtask
  // clear-to-send and line lights per port
  task automatic t_port(input int i);
    @(negedge ref_clk) {cts[i], rx_line[i], tx_line_in} = 4'b0000;
    repeat (3) @(negedge ref_clk);
    chk(port_status[i*8+:8] === 8'hff && port_status[(1-i)*8+:8] === 8'h00, "code");
    chk(tx_go[i] === 1'b0 && tx_line[i] === 1'b1 && tx_go[1-i] === 1'b1, "tx gate");
    chk(rxi[i] === 1'b1, "rx light");
    chk(txi[i] === 1'b0 && txi[1-i] === 1'b1, "tx light");
    chk(tx_line[1-i] === 1'b0, "tx follows");
    {cts[i], rx_line[i], tx_line_in} = 4'b1111;
    repeat (3) @(negedge ref_clk);
    chk(port_status === 16'h0000 && rxi === 2'b00, "released");
    chk(txi === 2'b00, "tx light off");
  endtask
  // stall the consumer until the buffer refuses, then release
  task automatic t_fill();
    @(negedge ref_clk) data_ready = 1'b0;
    repeat (60) @(negedge ref_clk) if (link.wr_ready === 1'b0) break;
    chk(link.wr_ready === 1'b0 && data_valid === 1'b1, "buffer full refusal");
    chk(data_word === 16'h5a5a && busy === 1'b1, "stalled word");
    data_ready = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(link.wr_ready === 1'b1, "buffer drains");
  endtask
  initial begin
    {rst_n, user_cfg, data_ready, cfg_word, user_data, host_paths} = {3'b001, 32'h5a5a, 8'h02};
    {cts, rx_line, tx_want, tx_line_in} = 8'hff;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk(cfg_indicator === 1'b1 && link.req_id === 8'h00, "after reset");
    t_cfg(16'h0214, 1'b1, 16'h0214);
    t_cfg(16'h0215, 1'b0, 16'h0214);
    t_cfg(16'h0003, 1'b0, 16'h0214);
    t_cfg(16'h0202, 1'b1, 16'h0202);
    t_seq();
    t_port(0);
    t_port(1);
    t_fill();
    print_verdict();
  end
endmodule
`default_nettype wire
